// ===== rtl/wlp_ctrl.sv
// APB register bank for wake-up sources, crystal select and low-power pin settings.
// Assumes an APB master on clk_sys and a power controller giving lowPowerMode.
`include "wlp_defines.svh"
module wlp_ctrl
    import wlp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire wlp_wake_t   wakePin,
    input  wire logic        lowPowerMode,
    input  wire wlp_sleep_t  normOutEnable,
    input  wire wlp_sleep_t  normValue,
    input  wire wlp_sleep_t  normDrive,
    input  wire wlp_sleep_t  normPull,
    output logic             wakeRequest,
    output wlp_wake_t        wakeMatch,
    output logic             crystalFreqSelect,
    output wlp_sleep_t       pinOutEnable,
    output wlp_sleep_t       pinOut,
    output wlp_sleep_t       pinDriveHigh,
    output wlp_sleep_t       pinPullEnable
);
    // ======================================================================
    // State
    typedef struct packed {
        wlp_bus_e   phase;       // APB phase tracker
        logic [31:0] rdata;      // Registered read data
        logic        err;        // Registered slave error
        wlp_wake_t   levelSel;   // Wake level per pin
        wlp_wake_t   pinEnable;  // Wake enable per pin
        logic        xtalSel;    // Crystal frequency select
        wlp_sleep_t  direction;  // Low-power direction, 1 input
        wlp_sleep_t  value;      // Low-power output value
        wlp_sleep_t  drive;      // Low-power drive strength
        wlp_sleep_t  pull;       // Low-power pull enable
    } wlp_ctrl_s;

    wlp_ctrl_s state;
    wlp_ctrl_s next_state;

    // ======================================================================
    // Address decode, shared by read and write paths
    function automatic wlp_sel_e decodeAddr(input logic [11:0] addr);
        case (addr)
            `WLP_OFS_WAKE_LEVEL_SELECT:  decodeAddr = WLP_SEL_LEVEL;
            `WLP_OFS_WAKE_PIN_ENABLE:    decodeAddr = WLP_SEL_ENABLE;
            `WLP_OFS_CRYSTAL_CONFIG:     decodeAddr = WLP_SEL_XTAL;
            `WLP_OFS_LOWPOWER_PIN_DIR:   decodeAddr = WLP_SEL_DIR;
            `WLP_OFS_LOWPOWER_PIN_VALUE: decodeAddr = WLP_SEL_VALUE;
            `WLP_OFS_LOWPOWER_PIN_DRIVE: decodeAddr = WLP_SEL_DRIVE;
            `WLP_OFS_LOWPOWER_PIN_PULL:  decodeAddr = WLP_SEL_PULL;
            default:                     decodeAddr = WLP_SEL_NONE;
        endcase
    endfunction

    wlp_sel_e    sel;       // Decoded register of the current transfer
    logic [31:0] readWord;  // Read mux output, reserved bits zero
    logic        doWrite;   // Write takes effect this edge
    logic        lowByteOk; // Byte lane 0 enabled; all fields sit there

    assign sel       = decodeAddr(paddr);
    assign lowByteOk = pstrb[0];
    assign doWrite   = psel & penable & pwrite & (sel != WLP_SEL_NONE) & lowByteOk;

    // Read mux: value register returns stored bits, never pin levels
    always_comb begin
        readWord = 32'h0000_0000;
        case (sel)
            WLP_SEL_LEVEL:  readWord[`WLP_WAKE_PINS-1:0]  = state.levelSel;
            WLP_SEL_ENABLE: readWord[`WLP_WAKE_PINS-1:0]  = state.pinEnable;
            WLP_SEL_XTAL:   readWord[`WLP_XTAL_BIT]       = state.xtalSel;
            WLP_SEL_DIR:    readWord[`WLP_SLEEP_PINS-1:0] = state.direction;
            WLP_SEL_VALUE:  readWord[`WLP_SLEEP_PINS-1:0] = state.value;
            WLP_SEL_DRIVE:  readWord[`WLP_SLEEP_PINS-1:0] = state.drive;
            WLP_SEL_PULL:   readWord[`WLP_SLEEP_PINS-1:0] = state.pull;
            default:        readWord = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // Next-state logic: APB phase tracking and register writes
    always_comb begin
        next_state = state;
        case (state.phase)
            WLP_BUS_IDLE: begin
                // Setup cycle seen; answer on the following access cycle
                if (psel && !penable) begin
                    next_state.phase = WLP_BUS_ACCESS;
                end
            end
            WLP_BUS_ACCESS: begin
                // Single-cycle access; back-to-back setup may follow
                next_state.phase = WLP_BUS_IDLE;
            end
            default: begin
                next_state.phase = WLP_BUS_IDLE;
            end
        endcase

        // Read data captured in setup so it is ready in the access cycle
        if (psel && !penable) begin
            next_state.rdata = pwrite ? 32'h0000_0000 : readWord;
            next_state.err   = (sel == WLP_SEL_NONE);
        end

        // Writes land only in the access cycle; reserved bits dropped
        if (doWrite) begin
            case (sel)
                WLP_SEL_LEVEL: begin
                    next_state.levelSel = pwdata[`WLP_WAKE_PINS-1:0];
                end
                WLP_SEL_ENABLE: begin
                    next_state.pinEnable = pwdata[`WLP_WAKE_PINS-1:0];
                end
                WLP_SEL_XTAL: begin
                    // Hardware never checks the fitted crystal
                    next_state.xtalSel = pwdata[`WLP_XTAL_BIT];
                end
                WLP_SEL_DIR: begin
                    next_state.direction = pwdata[`WLP_SLEEP_PINS-1:0];
                end
                WLP_SEL_VALUE: begin
                    next_state.value = pwdata[`WLP_SLEEP_PINS-1:0];
                end
                WLP_SEL_DRIVE: begin
                    next_state.drive = pwdata[`WLP_SLEEP_PINS-1:0];
                end
                WLP_SEL_PULL: begin
                    next_state.pull = pwdata[`WLP_SLEEP_PINS-1:0];
                end
                default: begin
                    next_state.err = 1'b1;
                end
            endcase
        end
    end

    // ======================================================================
    // Register stage with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state.phase     <= WLP_BUS_IDLE;
            state.rdata     <= 32'h0000_0000;
            state.err       <= 1'b0;
            state.levelSel  <= `WLP_RST_WAKE_LEVEL_SELECT;
            state.pinEnable <= `WLP_RST_WAKE_PIN_ENABLE;
            state.xtalSel   <= `WLP_RST_CRYSTAL_SELECT;
            state.direction <= `WLP_RST_LOWPOWER_PIN_DIR;
            state.value     <= `WLP_RST_LOWPOWER_PIN_VALUE;
            state.drive     <= `WLP_RST_LOWPOWER_PIN_DRIVE;
            state.pull      <= `WLP_RST_LOWPOWER_PIN_PULL;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // Bus outputs: ready is combinational, data from flops
    assign pready            = (state.phase == WLP_BUS_ACCESS);
    assign prdata            = state.rdata;
    assign pslverr           = pready & state.err;
    assign crystalFreqSelect = state.xtalSel;

    // ======================================================================
    // Wake detection
    wlp_wake_detect u_detect (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .wakePin         (wakePin),
        .wakeLevelSelect (state.levelSel),
        .wakePinEnable   (state.pinEnable),
        .wakeMatch       (wakeMatch),
        .wakeRequest     (wakeRequest)
    );

    // ======================================================================
    // Sleep-capable pins are wake pins 0 to 2
    wlp_pin_mux u_mux (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .lowPowerMode    (lowPowerMode),
        .wakeEnableSleep (state.pinEnable[`WLP_SLEEP_PINS-1:0]),
        .lpDirection     (state.direction),
        .lpValue         (state.value),
        .lpDrive         (state.drive),
        .lpPull          (state.pull),
        .normOutEnable   (normOutEnable),
        .normValue       (normValue),
        .normDrive       (normDrive),
        .normPull        (normPull),
        .pinOutEnable    (pinOutEnable),
        .pinOut          (pinOut),
        .pinDriveHigh    (pinDriveHigh),
        .pinPullEnable   (pinPullEnable)
    );
endmodule

// ===== include/wlp_defines.svh
// Register offsets, field positions, reset values of the wake-up and low-power pin bank.
// Assumes inclusion by bare name from any design or bench file.
`ifndef WLP_DEFINES_SVH
`define WLP_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define WLP_OFS_WAKE_LEVEL_SELECT  12'h000
`define WLP_OFS_WAKE_PIN_ENABLE    12'h004
`define WLP_OFS_CRYSTAL_CONFIG     12'h008
`define WLP_OFS_LOWPOWER_PIN_DIR   12'h00c
`define WLP_OFS_LOWPOWER_PIN_VALUE 12'h010
`define WLP_OFS_LOWPOWER_PIN_DRIVE 12'h014
`define WLP_OFS_LOWPOWER_PIN_PULL  12'h018

// ==========================================================================
// Field widths and crystal bit position
`define WLP_WAKE_PINS  5
`define WLP_SLEEP_PINS 3
`define WLP_XTAL_BIT   0

// ==========================================================================
// Reset values
`define WLP_RST_WAKE_LEVEL_SELECT  5'h00
`define WLP_RST_WAKE_PIN_ENABLE    5'h07
`define WLP_RST_CRYSTAL_SELECT     1'h0
`define WLP_RST_LOWPOWER_PIN_DIR   3'h7
`define WLP_RST_LOWPOWER_PIN_VALUE 3'h0
`define WLP_RST_LOWPOWER_PIN_DRIVE 3'h0
`define WLP_RST_LOWPOWER_PIN_PULL  3'h7

`endif

// ===== include/wlp_pkg.sv
// Types shared by the wake-up and low-power pin bank.
// Assumes wlp_defines.svh is on the include path.
`include "wlp_defines.svh"

package wlp_pkg;
    // ======================================================================
    // Register selector
    typedef enum {
        WLP_SEL_LEVEL,
        WLP_SEL_ENABLE,
        WLP_SEL_XTAL,
        WLP_SEL_DIR,
        WLP_SEL_VALUE,
        WLP_SEL_DRIVE,
        WLP_SEL_PULL,
        WLP_SEL_NONE
    } wlp_sel_e;

    // APB slave phase
    typedef enum {
        WLP_BUS_IDLE,
        WLP_BUS_ACCESS
    } wlp_bus_e;

    typedef logic [`WLP_WAKE_PINS-1:0]  wlp_wake_t;
    typedef logic [`WLP_SLEEP_PINS-1:0] wlp_sleep_t;
endpackage

// ===== rtl/wlp_wake_detect.sv
// Combined level-sensitive wake request from the five wake pins.
// Assumes pin levels are synchronous to clk_sys.
`include "wlp_defines.svh"
module wlp_wake_detect
    import wlp_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      rst,
    input  wire wlp_wake_t wakePin,
    input  wire wlp_wake_t wakeLevelSelect,
    input  wire wlp_wake_t wakePinEnable,
    output wlp_wake_t      wakeMatch,
    output logic           wakeRequest
);
    // ======================================================================
    // State
    typedef struct packed {
        wlp_wake_t match;   // Per-pin registered match
        logic      request; // Registered combined request
    } wlp_det_s;

    wlp_det_s state;
    wlp_det_s next_state;

    // Per-pin compare; a disabled pin is masked out regardless of level
    always_comb begin
        next_state = state;
        for (int i = 0; i < `WLP_WAKE_PINS; i++) begin
            next_state.match[i] = wakePinEnable[i]
                                  & ~(wakePin[i] ^ wakeLevelSelect[i]);
        end
        next_state.request = |next_state.match;
    end

    // Register, so the request is glitch free for the power controller
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wakeMatch   = state.match;
    assign wakeRequest = state.request;
endmodule

// ===== rtl/wlp_pin_mux.sv
// Selects low-power or normal settings for the three sleep-capable pins.
// Assumes the power controller flags low-power mode as a level on clk_sys.
`include "wlp_defines.svh"
module wlp_pin_mux
    import wlp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       lowPowerMode,
    input  wire wlp_sleep_t wakeEnableSleep,
    input  wire wlp_sleep_t lpDirection,
    input  wire wlp_sleep_t lpValue,
    input  wire wlp_sleep_t lpDrive,
    input  wire wlp_sleep_t lpPull,
    input  wire wlp_sleep_t normOutEnable,
    input  wire wlp_sleep_t normValue,
    input  wire wlp_sleep_t normDrive,
    input  wire wlp_sleep_t normPull,
    output wlp_sleep_t      pinOutEnable,
    output wlp_sleep_t      pinOut,
    output wlp_sleep_t      pinDriveHigh,
    output wlp_sleep_t      pinPullEnable
);
    typedef struct packed {
        wlp_sleep_t oe;
        wlp_sleep_t dout;
        wlp_sleep_t ds;
        wlp_sleep_t pe;
    } wlp_mux_s;

    wlp_mux_s state;
    wlp_mux_s next_state;

    // ======================================================================
    // Pin setting selection
    always_comb begin
        next_state = state;
        if (lowPowerMode) begin
            // Direction 0 means output; a wake source is forced to input
            next_state.oe   = ~lpDirection & ~wakeEnableSleep;
            next_state.dout = lpValue;
            next_state.ds   = lpDrive;
            next_state.pe   = lpPull;
        end else begin
            // Outside low power the normal configuration rules
            next_state.oe   = normOutEnable;
            next_state.dout = normValue;
            next_state.ds   = normDrive;
            next_state.pe   = normPull;
        end
    end

    // Reset leaves the pins undriven with pulls on
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state.oe   <= '0;
            state.dout <= '0;
            state.ds   <= '0;
            state.pe   <= `WLP_RST_LOWPOWER_PIN_PULL;
        end else begin
            state <= next_state;
        end
    end

    assign pinOutEnable  = state.oe;
    assign pinOut        = state.dout;
    assign pinDriveHigh  = state.ds;
    assign pinPullEnable = state.pe;
endmodule

// ===== verif/wlp_ctrl_monitor.sv
// Checker for wlp_ctrl: bus answer, readback, wake match and pin outputs.
// Assumes one clock clk_sys and sync active-high rst; bound to every wlp_ctrl.
`include "wlp_defines.svh"
module wlp_ctrl_monitor
    import wlp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire wlp_wake_t   wakePin,
    input  wire logic        lowPowerMode,
    input  wire wlp_sleep_t  normOutEnable,
    input  wire wlp_sleep_t  normValue,
    input  wire wlp_sleep_t  normDrive,
    input  wire wlp_sleep_t  normPull,
    input  wire logic        wakeRequest,
    input  wire wlp_wake_t   wakeMatch,
    input  wire logic        crystalFreqSelect,
    input  wire wlp_sleep_t  pinOutEnable,
    input  wire wlp_sleep_t  pinOut,
    input  wire wlp_sleep_t  pinDriveHigh,
    input  wire wlp_sleep_t  pinPullEnable
);
    // ======================================================================
    // Shadow copy of the seven registers, built from completed writes
    localparam logic [31:0] MASK [0:6] = '{32'h1f, 32'h1f, 32'h1, 32'h7, 32'h7, 32'h7, 32'h7};
    logic [31:0] sh [0:6];  // Expected register contents
    logic        wrOk;      // Accepted full write to a mapped register
    assign wrOk = psel && penable && pready && pwrite && !pslverr && pstrb[0];
    // Same edge as the design's registers, so $past lines up with outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sh <= '{32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0, 32'h7};
        end else if (wrOk) begin
            sh[paddr[4:2]] <= pwdata & MASK[paddr[4:2]];
        end
    end
    // ======================================================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_readDone;
        psel && penable && pready && !pwrite && !pslverr;
    endsequence
    property p_answer;
        s_setup |=> pready;
    endproperty
    property p_read;
        s_readDone |-> prdata == sh[paddr[4:2]];
    endproperty
    property p_match;
        1'b1 |=> wakeMatch == $past(~(wakePin ^ sh[0][4:0]) & sh[1][4:0]);
    endproperty
    property p_disabled;
        1'b1 |=> (wakeMatch & ~$past(sh[1][4:0])) == 5'h00;
    endproperty
    property p_request;
        wakeRequest == (|wakeMatch);
    endproperty
    property p_xtal;
        crystalFreqSelect == sh[2][0];
    endproperty
    property p_lpOut;
        lowPowerMode |=> pinOutEnable == $past(~sh[3][2:0] & ~sh[1][2:0])
            && pinOut == $past(sh[4][2:0]);
    endproperty
    property p_lpDrive;
        lowPowerMode |=> pinDriveHigh == $past(sh[5][2:0])
            && pinPullEnable == $past(sh[6][2:0]);
    endproperty
    property p_normal;
        // Reset edge excluded: pull output resets on, not to the normal setting
        !rst && !lowPowerMode |=> {pinOutEnable, pinOut, pinDriveHigh, pinPullEnable}
            == $past({normOutEnable, normValue, normDrive, normPull});
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    a_read: assert property (p_read) else $error("read data mismatch");
    a_match: assert property (p_match) else $error("wake match mismatch");
    a_disabled: assert property (p_disabled) else $error("disabled pin matched");
    a_request: assert property (p_request) else $error("wake request mismatch");
    a_xtal: assert property (p_xtal) else $error("crystal select mismatch");
    a_lpOut: assert property (p_lpOut) else $error("low-power output mismatch");
    a_lpDrive: assert property (p_lpDrive) else $error("low-power drive mismatch");
    a_normal: assert property (p_normal) else $error("normal pin mismatch");
endmodule

bind wlp_ctrl wlp_ctrl_monitor wlp_ctrl_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wakePin(wakePin),
    .lowPowerMode(lowPowerMode), .normOutEnable(normOutEnable), .normValue(normValue),
    .normDrive(normDrive), .normPull(normPull), .wakeRequest(wakeRequest),
    .wakeMatch(wakeMatch), .crystalFreqSelect(crystalFreqSelect),
    .pinOutEnable(pinOutEnable), .pinOut(pinOut), .pinDriveHigh(pinDriveHigh),
    .pinPullEnable(pinPullEnable));

// ===== verif/wlp_pin_partner.sv
// Board-side model of the five wake pins: board drivers, pulls, floating lines.
// Assumes sleep-pin outputs 0..2 sit on wake pins 0..2.
module wlp_pin_partner
    import wlp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire wlp_wake_t  boardDrive,
    input  wire wlp_wake_t  boardValue,
    input  wire wlp_sleep_t pinOutEnable,
    input  wire wlp_sleep_t pinOut,
    input  wire wlp_sleep_t pinPullEnable,
    output wlp_wake_t       wakePin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Wire level; registered so an undriven line can flip every cycle
    initial wakePin = 5'h1f;
    always @(posedge clk_sys) begin
        for (int i = 0; i < 5; i++) begin
            if (i < 3 && pinOutEnable[i % 3]) begin
                wakePin[i] <= pinOut[i % 3];      // Device drives the line
            end else if (boardDrive[i]) begin
                wakePin[i] <= boardValue[i];      // Board driver
            end else if (i < 3 && pinPullEnable[i % 3]) begin
                wakePin[i] <= 1'b1;               // Internal pull-up
            end else begin
                wakePin[i] <= ~wakePin[i];        // Floating: no stable level
            end
        end
    end
endmodule

// ===== verif/wlp_ctrl_tb.sv
// Self-checking bench for wlp_ctrl: registers over APB, wake detection, sleep pins.
// Assumes the checker binds itself and wlp_pin_partner drives wakePin.
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module wlp_ctrl_tb
    import wlp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Signals
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        lowPowerMode, wakeRequest, crystalFreqSelect;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    wlp_wake_t   wakePin, wakeMatch, boardDrive, boardValue;
    wlp_sleep_t  normOutEnable, normValue, normDrive, normPull;
    wlp_sleep_t  pinOutEnable, pinOut, pinDriveHigh, pinPullEnable;
    int          errors, n_checks;
    logic [31:0] RST [0:6] = '{32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0, 32'h7};
    logic [31:0] MSK [0:6] = '{32'h1f, 32'h1f, 32'h1, 32'h7, 32'h7, 32'h7, 32'h7};
    wlp_ctrl wlp_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wakePin(wakePin), .lowPowerMode(lowPowerMode),
        .normOutEnable(normOutEnable), .normValue(normValue), .normDrive(normDrive),
        .normPull(normPull), .wakeRequest(wakeRequest), .wakeMatch(wakeMatch),
        .crystalFreqSelect(crystalFreqSelect), .pinOutEnable(pinOutEnable),
        .pinOut(pinOut), .pinDriveHigh(pinDriveHigh), .pinPullEnable(pinPullEnable));
    wlp_pin_partner wlp_pin_partner_inst (.clk_sys(clk_sys), .boardDrive(boardDrive),
        .boardValue(boardValue), .pinOutEnable(pinOutEnable), .pinOut(pinOut),
        .pinPullEnable(pinPullEnable), .wakePin(wakePin));
    // ======================================================================
    // Clock and closing
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog: the whole run needs well under 3000 cycles
    initial begin
        #40000;
        errors++;
        end_of_test();
    end
    // ======================================================================
    // APB master: setup, access held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Read just after an edge, outputs still show what that edge sampled
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 16) errors++;  // Slave never answered
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Let registered outputs and the pin model catch up; ends on a rising edge
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, 4'hf);
            `CHK("reset value", RST[i], rd)
        end
        apb(1'b0, 12'h01c, 32'h0, 4'hf);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, 12'h01c, 32'hffffffff, 4'hf);
        `CHK("unmapped write error", 1'b1, err)
        $display("test reset done");
    endtask
    task automatic t_readback();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 12'(i * 4), 32'hffffffff, 4'hf);
            apb(1'b1, 12'(i * 4), 32'h0, 4'h0);  // Strobe off: must be dropped
            apb(1'b0, 12'(i * 4), 32'h0, 4'hf);
            `CHK("readback", MSK[i], rd)
            apb(1'b1, 12'(i * 4), RST[i], 4'hf);
        end
        $display("test readback done");
    endtask
    task automatic t_wake();
        boardDrive <= 5'h1f;
        boardValue <= 5'h1f;
        settle();
        `CHK("wake idle", 1'b0, wakeRequest)
        boardValue <= 5'h17;  // Pin 3 low but not enabled
        settle();
        `CHK("disabled pin", 1'b0, wakeRequest)
        apb(1'b1, 12'h004, 32'h18, 4'hf);
        apb(1'b1, 12'h000, 32'h10, 4'hf);
        settle();
        `CHK("high level match", 5'h18, wakeMatch)
        `CHK("high level wake", 1'b1, wakeRequest)
        boardValue <= 5'h07;
        settle();
        `CHK("low level match", 5'h08, wakeMatch)
        $display("test wake done");
    endtask
    task automatic t_lowpower();
        boardDrive <= 5'h18;
        apb(1'b1, 12'h004, 32'h01, 4'hf);
        apb(1'b1, 12'h00c, 32'h0, 4'hf);
        apb(1'b1, 12'h010, 32'h6, 4'hf);
        apb(1'b1, 12'h014, 32'h5, 4'hf);
        apb(1'b1, 12'h018, 32'h2, 4'hf);
        lowPowerMode <= 1'b1;
        settle();
        `CHK("lp output enable", 3'h6, pinOutEnable)
        `CHK("lp output value", 3'h6, pinOut)
        `CHK("lp wire level", 2'h3, wakePin[2:1])
        `CHK("lp drive", 3'h5, pinDriveHigh)
        `CHK("lp pull", 3'h2, pinPullEnable)
        normOutEnable <= 3'h3;
        normValue <= 3'h1;
        normDrive <= 3'h2;
        normPull <= 3'h4;
        lowPowerMode <= 1'b0;
        settle();
        `CHK("normal pins", 9'h0ca, {pinOutEnable, pinOut, pinDriveHigh})
        `CHK("normal pull", 3'h4, pinPullEnable)
        $display("test lowpower done");
    endtask
    task automatic t_xtal();
        apb(1'b1, 12'h008, 32'h1, 4'hf);  // Board fitted with the faster crystal
        settle();
        `CHK("crystal 32", 1'b1, crystalFreqSelect)
        apb(1'b1, 12'h008, 32'h0, 4'hf);
        settle();
        `CHK("crystal 16", 1'b0, crystalFreqSelect)
        $display("test xtal done");
    endtask
    // ======================================================================
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, lowPowerMode} = 5'h10;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        {normOutEnable, normValue, normDrive, normPull} = 12'h0;
        boardDrive = 5'h1f;
        boardValue = 5'h1f;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_readback();
        t_wake();
        t_lowpower();
        t_xtal();
        end_of_test();
    end
endmodule
